/* File: design/pfr_fault_resp.sv */
// limit registers and over-temperature fault response sequencer
`timescale 1ns/10ps
`default_nettype none
module pfr_fault_resp
    import pfr_pkg::*;
(
    input wire logic clk,                // core clock, 200 MHz
    input wire logic arst_n,             // bias power reset, active low
    input wire logic clk_en,             // freezes all state when low
    input wire logic cmd_wr,             // write transfer strobe
    input wire logic cmd_rd,             // read transfer strobe
    input wire logic [7:0] cmd_code,     // command code
    input wire logic cmd_word,           // 1 word transfer, 0 byte
    input wire logic [15:0] wr_data,     // write data, byte in low bits
    input wire logic [15:0] temp_meas,   // temperature, linear format
    input wire logic unit_tick,          // delay unit pulse
    input wire logic status_clr,         // status bit cleared
    input wire logic clear_faults,       // clear-faults command
    input wire logic reset_pin,          // reset pin, asynchronous
    input wire logic on_cmd,             // output commanded on
    output logic [15:0] rd_data_reg,     // read data
    output logic rd_valid_reg,           // read data valid pulse
    output logic cmd_err_reg,            // bad code or size pulse
    output logic out_enable_reg,         // output enable
    output logic shutdown_reg,           // output shut by fault
    output logic fault_latched_reg,      // latched fault status
    output logic [15:0] oc_lv_limit_reg, // over-current low-voltage threshold
    output logic [15:0] oc_warn_limit_reg // over-current warning limit
);
    logic [15:0] ot_limit_reg;
    logic [7:0] ot_react_reg;
    logic rst_meta_reg, rst_sync_reg, on_prev_reg;
    logic [2:0] tries_reg, tries_next;
    pfr_state_t state_reg, state_next;
    logic tmr_start, tmr_done, fault_now, clear_evt, size_ok, mapped;
    logic [1:0] resp;
    logic [2:0] retry_set;

    // linear word as a common fixed-point value: mantissa shifted by exponent + 16
    function automatic logic signed [47:0] lin_val(input logic [15:0] w);
        logic signed [47:0] m;
        logic [4:0] sh;
        m = 48'(signed'(w[10:0]));
        sh = w[15:11] + 5'h10;
        return m <<< sh;
    endfunction : lin_val

    assign resp = ot_react_reg[PFR_RESP_HI:PFR_RESP_LO];
    assign retry_set = ot_react_reg[PFR_RETRY_HI:PFR_RETRY_LO];
    assign fault_now = lin_val(temp_meas) >= lin_val(ot_limit_reg);
    // bias loss acts through arst_n; the rest arrive here
    assign clear_evt = status_clr | clear_faults | rst_sync_reg | (on_cmd & ~on_prev_reg);
    assign mapped = (cmd_code == PFR_CMD_OC_LV_LIMIT) || (cmd_code == PFR_CMD_OC_WARN_LIMIT)
        || (cmd_code == PFR_CMD_OT_LIMIT) || (cmd_code == PFR_CMD_OT_REACTION);
    assign size_ok = (cmd_code == PFR_CMD_OT_REACTION) ? !cmd_word : cmd_word;

    // reset pin crosses into the clock domain through two flops
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_meta_reg <= 1'b0;
            rst_sync_reg <= 1'b0;
            on_prev_reg <= 1'b1; // on idles high, so no false off-then-on after reset
        end
        else if (clk_en)
        begin
            rst_meta_reg <= reset_pin;
            rst_sync_reg <= rst_meta_reg;
            on_prev_reg <= on_cmd;
        end
    end

    // register writes; a wrong-size or unknown transfer changes nothing
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            oc_lv_limit_reg <= PFR_RST_OC_LV_LIMIT;
            oc_warn_limit_reg <= PFR_RST_OC_WARN_LIMIT;
            ot_limit_reg <= PFR_RST_OT_LIMIT;
            ot_react_reg <= PFR_RST_OT_REACTION;
        end
        else if (clk_en && cmd_wr && mapped && size_ok)
        begin
            unique case (cmd_code)
                PFR_CMD_OC_LV_LIMIT: oc_lv_limit_reg <= wr_data;
                PFR_CMD_OC_WARN_LIMIT: oc_warn_limit_reg <= wr_data;
                PFR_CMD_OT_LIMIT: ot_limit_reg <= wr_data;
                default: ot_react_reg <= wr_data[7:0];
            endcase
        end
    end

    // read answers one cycle after the strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rd_data_reg <= 16'h0000;
            rd_valid_reg <= 1'b0;
            cmd_err_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            rd_valid_reg <= cmd_rd && mapped && size_ok;
            cmd_err_reg <= (cmd_rd || cmd_wr) && !(mapped && size_ok);
            if (cmd_rd && mapped && size_ok)
            begin
                unique case (cmd_code)
                    PFR_CMD_OC_LV_LIMIT: rd_data_reg <= oc_lv_limit_reg;
                    PFR_CMD_OC_WARN_LIMIT: rd_data_reg <= oc_warn_limit_reg;
                    PFR_CMD_OT_LIMIT: rd_data_reg <= ot_limit_reg;
                    default: rd_data_reg <= {8'h00, ot_react_reg};
                endcase
            end
        end
    end

    // sequencer: clear or commanded off always returns to the running state
    always_comb
    begin
        state_next = state_reg;
        tries_next = tries_reg;
        tmr_start = 1'b0;
        if (clear_evt || !on_cmd)
        begin
            state_next = PFR_ST_RUN;
            tries_next = 3'h0;
        end
        else
        begin
            unique case (state_reg)
                PFR_ST_RUN:
                    if (fault_now)
                    begin
                        unique case (resp)
                            PFR_RESP_IGNORE: state_next = PFR_ST_RUN;
                            PFR_RESP_DELAY:
                            begin
                                state_next = PFR_ST_WAIT_DLY;
                                tmr_start = 1'b1;
                            end
                            PFR_RESP_DISABLE:
                            begin
                                tries_next = 3'h0;
                                tmr_start = 1'b1;
                                state_next = (retry_set == PFR_RETRY_NONE) ? PFR_ST_LATCH
                                    : PFR_ST_OFF_WAIT;
                            end
                            PFR_RESP_LATCH: state_next = PFR_ST_LATCH;
                        endcase
                    end
                PFR_ST_WAIT_DLY:
                    if (!fault_now)
                        state_next = PFR_ST_RUN;
                    else if (tmr_done)
                    begin
                        tries_next = 3'h0;
                        tmr_start = 1'b1;
                        state_next = (retry_set == PFR_RETRY_NONE) ? PFR_ST_LATCH
                            : PFR_ST_OFF_WAIT;
                    end
                PFR_ST_OFF_WAIT:
                    if (tmr_done)
                    begin
                        state_next = PFR_ST_TRY;
                        tmr_start = 1'b1;
                        if (retry_set != PFR_RETRY_ENDLESS)
                            tries_next = tries_reg + 3'h1;
                    end
                PFR_ST_TRY:
                    if (fault_now)
                    begin
                        tmr_start = 1'b1;
                        // a failed last attempt ends the sequence
                        state_next = (retry_set != PFR_RETRY_ENDLESS && tries_reg >= retry_set)
                            ? PFR_ST_LATCH : PFR_ST_OFF_WAIT;
                    end
                    else if (tmr_done)
                        state_next = PFR_ST_RUN;
                PFR_ST_LATCH: state_next = PFR_ST_LATCH;
            endcase
        end
    end

    // state, attempt count and the registered output decision
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_reg <= PFR_ST_RUN;
            tries_reg <= 3'h0;
            out_enable_reg <= 1'b0;
            shutdown_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            state_reg <= state_next;
            tries_reg <= tries_next;
            out_enable_reg <= on_cmd && (state_next == PFR_ST_RUN
                || state_next == PFR_ST_WAIT_DLY || state_next == PFR_ST_TRY);
            shutdown_reg <= state_next == PFR_ST_OFF_WAIT || state_next == PFR_ST_LATCH;
        end
    end

    // status flag: a fault while on_cmd is high in the same cycle as a clear keeps the flag set
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            fault_latched_reg <= 1'b0;
        else if (clk_en)
        begin
            if (fault_now && on_cmd)
                fault_latched_reg <= 1'b1;
            else if (clear_evt)
                fault_latched_reg <= 1'b0;
        end
    end

    pfr_delay_timer u_timer (
        .clk(clk),
        .arst_n(arst_n),
        .clk_en(clk_en),
        .start(tmr_start),
        .unit_tick(unit_tick),
        .exp_sel(ot_react_reg[PFR_DELAY_HI:PFR_DELAY_LO]),
        .done_reg(tmr_done)
    );

    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    property p_ignore;
        clk_en && on_cmd && state_reg == PFR_ST_RUN && resp == PFR_RESP_IGNORE
            && !clear_evt |=> out_enable_reg;
    endproperty
    a_ignore: assert property (p_ignore) else $error("ignored fault stopped output");
    property p_disable;
        clk_en && on_cmd && !clear_evt && state_reg == PFR_ST_RUN && fault_now
            && resp == PFR_RESP_DISABLE |=> !out_enable_reg && shutdown_reg;
    endproperty
    a_disable: assert property (p_disable) else $error("disable response kept output");
    property p_latch;
        clk_en && on_cmd && !clear_evt && state_reg == PFR_ST_RUN && fault_now
            && resp == PFR_RESP_LATCH |=> state_reg == PFR_ST_LATCH && !out_enable_reg;
    endproperty
    a_latch: assert property (p_latch) else $error("latch response not taken");
    property p_latch_hold;
        clk_en && state_reg == PFR_ST_LATCH && on_cmd && !clear_evt |=> !out_enable_reg;
    endproperty
    a_latch_hold: assert property (p_latch_hold) else $error("latched output came back");
    property p_clear;
        clk_en && clear_faults && !(fault_now && on_cmd) |=> !fault_latched_reg
            && state_reg == PFR_ST_RUN;
    endproperty
    a_clear: assert property (p_clear) else $error("clear did not release fault");
    property p_wr_limit;
        clk_en && cmd_wr && cmd_word && cmd_code == PFR_CMD_OT_LIMIT
            |=> ot_limit_reg == $past(wr_data);
    endproperty
    a_wr_limit: assert property (p_wr_limit) else $error("limit write lost");
    property p_byte_only;
        clk_en && (cmd_wr || cmd_rd) && cmd_word && cmd_code == PFR_CMD_OT_REACTION
            |=> cmd_err_reg && $stable(ot_react_reg);
    endproperty
    a_byte_only: assert property (p_byte_only) else $error("word access to byte register");
    property p_tries;
        retry_set != PFR_RETRY_ENDLESS && state_reg == PFR_ST_TRY |-> tries_reg <= retry_set;
    endproperty
    a_tries: assert property (p_tries) else $error("too many restarts");
    property p_try_spacing;
        clk_en && on_cmd && !clear_evt && state_reg == PFR_ST_OFF_WAIT && !tmr_done
            |=> state_reg == PFR_ST_OFF_WAIT && !out_enable_reg;
    endproperty
    a_try_spacing: assert property (p_try_spacing) else $error("restart before delay");
    property p_rd_word;
        clk_en && cmd_rd && cmd_word && cmd_code == PFR_CMD_OC_LV_LIMIT
            |=> rd_valid_reg && rd_data_reg == oc_lv_limit_reg;
    endproperty
    a_rd_word: assert property (p_rd_word) else $error("read returned wrong word");

    c_latch: cover property (state_reg == PFR_ST_LATCH);
    c_retry: cover property (state_reg == PFR_ST_TRY ##1 state_reg == PFR_ST_OFF_WAIT);
    c_recover: cover property (state_reg == PFR_ST_TRY ##1 state_reg == PFR_ST_RUN);
    c_delay_ok: cover property (state_reg == PFR_ST_WAIT_DLY ##1 state_reg == PFR_ST_RUN);
endmodule : pfr_fault_resp
`default_nettype wire

/* File: design/pfr_pkg.sv */
// shared constants and types for the fault limit and over-temperature response block
package pfr_pkg;
    // command codes of the limit and response registers
    localparam logic [7:0] PFR_CMD_OC_LV_LIMIT = 8'h48;
    localparam logic [7:0] PFR_CMD_OC_WARN_LIMIT = 8'h4A;
    localparam logic [7:0] PFR_CMD_OT_LIMIT = 8'h4F;
    localparam logic [7:0] PFR_CMD_OT_REACTION = 8'h50;
    // values after reset
    localparam logic [15:0] PFR_RST_OC_LV_LIMIT = 16'h0000;
    localparam logic [15:0] PFR_RST_OC_WARN_LIMIT = 16'h0000;
    // largest positive linear value: a mantissa of 7FF would read as -1 and trip at once
    localparam logic [15:0] PFR_RST_OT_LIMIT = 16'h7BFF;
    localparam logic [7:0] PFR_RST_OT_REACTION = 8'h80;
    // field positions of the reaction byte
    localparam int PFR_RESP_HI = 7;
    localparam int PFR_RESP_LO = 6;
    localparam int PFR_RETRY_HI = 5;
    localparam int PFR_RETRY_LO = 3;
    localparam int PFR_DELAY_HI = 2;
    localparam int PFR_DELAY_LO = 0;
    // response codes
    localparam logic [1:0] PFR_RESP_IGNORE = 2'h0;
    localparam logic [1:0] PFR_RESP_DELAY = 2'h1;
    localparam logic [1:0] PFR_RESP_DISABLE = 2'h2;
    localparam logic [1:0] PFR_RESP_LATCH = 2'h3;
    // retry field values
    localparam logic [2:0] PFR_RETRY_NONE = 3'h0;
    localparam logic [2:0] PFR_RETRY_ENDLESS = 3'h7;
    // delay counter width, enough for 128 units
    localparam int PFR_DCNT_W = 8;

    typedef enum logic [2:0] {
        PFR_ST_RUN,
        PFR_ST_WAIT_DLY,
        PFR_ST_OFF_WAIT,
        PFR_ST_TRY,
        PFR_ST_LATCH
    } pfr_state_t;
endpackage : pfr_pkg

/* File: design/pfr_delay_timer.sv */
// delay timer counting 2**n delay-unit ticks
`timescale 1ns/10ps
`default_nettype none
module pfr_delay_timer
    import pfr_pkg::*;
(
    input wire logic clk,                // core clock
    input wire logic arst_n,             // async reset, active low
    input wire logic clk_en,             // freezes the timer when low
    input wire logic start,              // restart the interval
    input wire logic unit_tick,          // one pulse per delay unit
    input wire logic [2:0] exp_sel,      // interval is 2**exp_sel units
    output logic done_reg                // pulse at interval end
);
    logic [PFR_DCNT_W-1:0] cnt_reg;
    logic busy_reg;

    // start wins over a running count so a new interval is always full length
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            cnt_reg <= '0;
            busy_reg <= 1'b0;
            done_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            done_reg <= 1'b0;
            if (start)
            begin
                cnt_reg <= PFR_DCNT_W'(1) << exp_sel;
                busy_reg <= 1'b1;
            end
            else if (busy_reg && unit_tick)
            begin
                cnt_reg <= cnt_reg - PFR_DCNT_W'(1);
                if (cnt_reg == PFR_DCNT_W'(1))
                begin
                    busy_reg <= 1'b0;
                    done_reg <= 1'b1;
                end
            end
        end
    end
endmodule : pfr_delay_timer
`default_nettype wire

/* File: bench/pfr_host_model.sv */
// host-side model that issues register read and write transfers
`timescale 1ns/10ps
`default_nettype none
module pfr_host_model
(
    input wire logic clk,            // core clock
    input wire logic [15:0] rd_data, // read data from device
    input wire logic rd_valid,       // read answer strobe
    input wire logic cmd_err,        // refusal strobe
    output var logic cmd_wr,         // write strobe
    output var logic cmd_rd,         // read strobe
    output var logic [7:0] cmd_code, // command code
    output var logic cmd_word,       // word or byte size
    output var logic [15:0] wr_data  // write data
);
    // idle bus at time zero
    initial
    begin
        cmd_wr = 1'h0;
        cmd_rd = 1'h0;
        cmd_code = 8'h00;
        cmd_word = 1'h0;
        wr_data = 16'h0000;
    end

    // one transfer: qualifiers stand from launch edge to the taking edge, answer read after it
    task automatic xfer(input logic wr, input logic [7:0] code, input logic word,
        input logic [15:0] data, output logic [15:0] rdat, output logic valid, output logic err);
        @(posedge clk);
        cmd_wr <= wr;
        cmd_rd <= !wr;
        cmd_code <= code;
        cmd_word <= word;
        wr_data <= wr ? data : ~wr_data;
        @(posedge clk);
        cmd_wr <= 1'h0;
        cmd_rd <= 1'h0;
        // a released data bus does not keep its last value
        wr_data <= ~data;
        #1;
        rdat = rd_data;
        valid = rd_valid;
        err = cmd_err;
    endtask : xfer
endmodule : pfr_host_model
`default_nettype wire

/* File: bench/pfr_fault_resp_tb.sv */
// self-checking bench for the fault limit and over-temperature response block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin err_count++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, got); end end
module pfr_fault_resp_tb
    import pfr_pkg::*;
;
    localparam logic [15:0] HOT = 16'h0078;
    localparam logic [15:0] LIM = 16'h0064;
    localparam logic [15:0] COOL = 16'h0032;
    logic clk = 1'h0, arst_n = 1'h0, clk_en = 1'h1, unit_tick = 1'h0;
    logic status_clr = 1'h0, clear_faults = 1'h0, reset_pin = 1'h0, on_cmd = 1'h1;
    logic [15:0] temp_meas = COOL;
    logic cmd_wr, cmd_rd, cmd_word, rd_valid_reg, cmd_err_reg;
    logic out_enable_reg, shutdown_reg, fault_latched_reg;
    logic [7:0] cmd_code;
    logic [15:0] wr_data, rd_data_reg, oc_lv_limit_reg, oc_warn_limit_reg;
    logic [2:0] tick_cnt = 3'h0;
    int err_count = 0, samples_checked = 0;

    always #2.5 clk = ~clk;

    // delay unit source: one pulse every fifth cycle, so latency never hides a tick
    always @(posedge clk)
    begin
        tick_cnt <= (tick_cnt == 3'h4) ? 3'h0 : tick_cnt + 3'h1;
        unit_tick <= (tick_cnt == 3'h4);
    end

    pfr_fault_resp dut_u (.clk(clk), .arst_n(arst_n), .clk_en(clk_en), .cmd_wr(cmd_wr),
        .cmd_rd(cmd_rd), .cmd_code(cmd_code), .cmd_word(cmd_word), .wr_data(wr_data),
        .temp_meas(temp_meas), .unit_tick(unit_tick), .status_clr(status_clr),
        .clear_faults(clear_faults), .reset_pin(reset_pin), .on_cmd(on_cmd),
        .rd_data_reg(rd_data_reg), .rd_valid_reg(rd_valid_reg), .cmd_err_reg(cmd_err_reg),
        .out_enable_reg(out_enable_reg), .shutdown_reg(shutdown_reg),
        .fault_latched_reg(fault_latched_reg), .oc_lv_limit_reg(oc_lv_limit_reg),
        .oc_warn_limit_reg(oc_warn_limit_reg));

    pfr_host_model host_u (.clk(clk), .rd_data(rd_data_reg), .rd_valid(rd_valid_reg),
        .cmd_err(cmd_err_reg), .cmd_wr(cmd_wr), .cmd_rd(cmd_rd), .cmd_code(cmd_code),
        .cmd_word(cmd_word), .wr_data(wr_data));

    // wait n edges and let their updates land
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic endt(input string nm);
        $display("test %s done, mismatches %0d", nm, err_count);
    endtask : endt

    // one transfer judged against the expected answer
    task automatic acc(input logic wr, input logic [7:0] code, input logic word,
        input logic [15:0] data, input logic exp_err, input logic [15:0] exp_rd);
        logic [15:0] r;
        logic v;
        logic e;
        host_u.xfer(wr, code, word, data, r, v, e);
        `CHK("cmd_err", exp_err, e)
        if (!wr)
            `CHK("rd_valid", !exp_err, v)
        if (!wr && !exp_err)
            `CHK("rd_data", exp_rd, r)
    endtask : acc

    // program the reaction byte, then cycle the output off and on from a cool state
    task automatic set_resp(input logic [7:0] b);
        acc(1'h1, PFR_CMD_OT_REACTION, 1'h0, {8'h00, b}, 1'h0, 16'h0000);
        @(posedge clk);
        temp_meas <= COOL;
        on_cmd <= 1'h0;
        repeat (3) @(posedge clk);
        on_cmd <= 1'h1;
        step(3);
    endtask : set_resp

    task automatic t_regs();
        acc(1'h0, PFR_CMD_OC_LV_LIMIT, 1'h1, 16'h0000, 1'h0, PFR_RST_OC_LV_LIMIT);
        acc(1'h0, PFR_CMD_OC_WARN_LIMIT, 1'h1, 16'h0000, 1'h0, PFR_RST_OC_WARN_LIMIT);
        acc(1'h0, PFR_CMD_OT_LIMIT, 1'h1, 16'h0000, 1'h0, PFR_RST_OT_LIMIT);
        acc(1'h0, PFR_CMD_OT_REACTION, 1'h0, 16'h0, 1'h0, {8'h00, PFR_RST_OT_REACTION});
        acc(1'h1, PFR_CMD_OC_LV_LIMIT, 1'h1, 16'hA5C3, 1'h0, 16'h0000);
        acc(1'h1, PFR_CMD_OC_WARN_LIMIT, 1'h1, 16'h5A3C, 1'h0, 16'h0000);
        acc(1'h1, PFR_CMD_OT_LIMIT, 1'h1, 16'h8001, 1'h0, 16'h0000);
        acc(1'h1, PFR_CMD_OT_REACTION, 1'h0, 16'h00D1, 1'h0, 16'h0000);
        // wrong sizes and an unmapped code are refused and leave contents alone
        acc(1'h1, PFR_CMD_OC_LV_LIMIT, 1'h0, 16'h0011, 1'h1, 16'h0000);
        acc(1'h1, PFR_CMD_OT_REACTION, 1'h1, 16'h1234, 1'h1, 16'h0000);
        acc(1'h0, 8'h49, 1'h1, 16'h0000, 1'h1, 16'h0000);
        acc(1'h0, PFR_CMD_OC_LV_LIMIT, 1'h1, 16'h0000, 1'h0, 16'hA5C3);
        acc(1'h0, PFR_CMD_OC_WARN_LIMIT, 1'h1, 16'h0000, 1'h0, 16'h5A3C);
        acc(1'h0, PFR_CMD_OT_LIMIT, 1'h1, 16'h0000, 1'h0, 16'h8001);
        acc(1'h0, PFR_CMD_OT_REACTION, 1'h0, 16'h0000, 1'h0, 16'h00D1);
        `CHK("oc_lv_limit", 16'hA5C3, oc_lv_limit_reg)
        `CHK("oc_warn_limit", 16'h5A3C, oc_warn_limit_reg)
        acc(1'h1, PFR_CMD_OT_LIMIT, 1'h1, LIM, 1'h0, 16'h0000);
        endt("regs");
    endtask : t_regs

    task automatic t_ignore();
        logic bad;
        bad = 1'h0;
        set_resp(8'h00);
        @(posedge clk);
        temp_meas <= HOT;
        repeat (60)
        begin
            step(1);
            bad |= (out_enable_reg !== 1'h1) || (shutdown_reg !== 1'h0);
        end
        `CHK("ignore_run", 1'h0, bad)
        endt("ignore");
    endtask : t_ignore

    // latch at the exact limit, then clear it by each of the clearing events
    task automatic t_latch();
        for (int k = 0; k < 5; k++)
        begin
            set_resp(8'hC0);
            @(posedge clk);
            temp_meas <= LIM;
            step(2);
            `CHK("latch_off", 1'h0, out_enable_reg)
            `CHK("latch_flag", 1'h1, fault_latched_reg)
            @(posedge clk);
            temp_meas <= COOL;
            step(20);
            `CHK("latch_hold", 1'h0, out_enable_reg)
            // a frozen clock enable must swallow a clear request
            @(posedge clk);
            clk_en <= 1'h0;
            clear_faults <= 1'h1;
            step(3);
            `CHK("frozen", 1'h1, fault_latched_reg & ~out_enable_reg)
            @(posedge clk);
            clk_en <= 1'h1;
            clear_faults <= 1'h0;
            @(posedge clk);
            case (k)
                0: status_clr <= 1'h1;
                1: clear_faults <= 1'h1;
                2: on_cmd <= 1'h0;
                3: reset_pin <= 1'h1;
                default: arst_n <= 1'h0;
            endcase
            @(posedge clk);
            status_clr <= 1'h0;
            clear_faults <= 1'h0;
            repeat (3) @(posedge clk);
            on_cmd <= 1'h1;
            reset_pin <= 1'h0;
            arst_n <= 1'h1;
            step(6);
            `CHK("clr_flag", 1'h0, fault_latched_reg)
            `CHK("clr_run", 1'h1, out_enable_reg)
        end
        // bias loss put the limit back to its reset value
        acc(1'h1, PFR_CMD_OT_LIMIT, 1'h1, LIM, 1'h0, 16'h0000);
        endt("latch");
    endtask : t_latch

    // disable-and-retry with every retry setting against a fault that never goes away
    task automatic t_retry();
        int rises;
        logic prev;
        for (int r = 0; r < 8; r++)
        begin
            set_resp({2'h2, r[2:0], 3'h0});
            @(posedge clk);
            temp_meas <= HOT;
            step(1);
            `CHK("dis_now", 1'h0, out_enable_reg)
            `CHK("dis_shut", 1'h1, shutdown_reg)
            rises = 0;
            prev = 1'h0;
            repeat (400)
            begin
                step(1);
                rises += (out_enable_reg === 1'h1 && prev !== 1'h1) ? 1 : 0;
                prev = out_enable_reg;
            end
            if (r < 7)
                `CHK("restarts", r, rises)
            else
                `CHK("endless", 1'h1, rises > 6)
            `CHK("final_off", 1'h0, out_enable_reg & (r < 7))
        end
        endt("retry");
    endtask : t_retry

    // run-on delay and restart spacing measured in unit ticks, one tick of slack
    task automatic t_delay();
        int n;
        int d;
        for (int i = 0; i < 3; i++)
        begin
            d = (i == 2) ? 5 : i + 2;
            set_resp({5'h09, d[2:0]});
            @(posedge clk);
            temp_meas <= HOT;
            n = 0;
            for (int c = 0; c < 2000 && out_enable_reg === 1'h1; c++)
            begin
                step(1);
                n += unit_tick;
            end
            `CHK("run_delay", 1'h1, n >= (1 << d) - 1 && n <= (1 << d) + 1)
            n = 0;
            for (int c = 0; c < 2000 && out_enable_reg !== 1'h1; c++)
            begin
                step(1);
                n += unit_tick;
            end
            `CHK("retry_gap", 1'h1, n >= (1 << d) - 1 && n <= (1 << d) + 1)
            step(40);
            `CHK("once_off", 1'h0, out_enable_reg)
        end
        // a fault that clears before the delay ends never stops the output
        set_resp(8'h4B);
        @(posedge clk);
        temp_meas <= HOT;
        repeat (15) @(posedge clk);
        temp_meas <= COOL;
        step(80);
        `CHK("brief_fault", 1'h1, out_enable_reg)
        endt("delay");
    endtask : t_delay

    task automatic print_verdict();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : print_verdict

    // main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        arst_n <= 1'h1;
        t_regs();
        t_ignore();
        t_latch();
        t_retry();
        t_delay();
        print_verdict();
    end

    // watchdog: the tests need well under half this span
    initial
    begin
        repeat (20000) @(posedge clk);
        err_count++;
        print_verdict();
    end
endmodule : pfr_fault_resp_tb
`default_nettype wire
